// [tcb_consts.svh]
// Constants for the level value and input select register bank.
// Assumes an APB slave with 32-bit data; printed offsets are indices, byte address is index times four.
// Summary of operation
// [R1] Index 0x29 holds value 0 in bits 9:0 and value 1 in bits 19:10.
// [R2] Index 0x2a holds value 2 low and value 3 in bits 19:10.
// [R3] Index 0x2b holds value 4 in bits 9:0 and value 5 in bits 19:10.
// [R4] Index 0x2c holds value 6 low, value 7 high; resets to zero here.
// [R5] Index 0x2d holds value 8 low, value 9 high; resets to zero here.
// [R6] Each field's lowest bit is its least significant bit.
// [R7] Bits 31:20 of each level value register read as zero.
// [R8] Index 0x2e holds eight 3-bit selectors, input n at bits 3n+2:3n.
// [R9] Selector k routes stored value k to its input; values 8, 9 unselectable.
// [R10] Selector register reads zero after reset, so inputs use value 0.
// [R11] Values 8 and 9 are driven out as levels for the highest channels.
// [R12] Writes to reserved bits are dropped; those bits keep reading zero.
`ifndef TCB_CONSTS_SVH
`define TCB_CONSTS_SVH
`define TCB_IDX_VAL01 8'h29
`define TCB_IDX_VAL23 8'h2a
`define TCB_IDX_VAL45 8'h2b
`define TCB_IDX_VAL67 8'h2c
`define TCB_IDX_VAL89 8'h2d
`define TCB_IDX_SEL 8'h2e
`define TCB_LO_LSB 0
`define TCB_HI_LSB 10
`define TCB_VAL_W 10
`define TCB_SEL_W 3
`define TCB_VAL_RST 10'h000
`define TCB_SEL_RST 24'h000000
`define TCB_VAL_MASK 32'h000fffff
`define TCB_SEL_MASK 32'h00ffffff
`endif

// [tcb_pkg.sv]
// Types shared by the level value bank.
// Assumes the constants header is included by the users.
package tcb_pkg;
   typedef logic [9:0] tcb_level_t;
   typedef logic [2:0] tcb_sel_t;
   typedef enum logic [1:0] {TCB_IDLE, TCB_ACCESS} tcb_state_t;
endpackage

// [tcb_level_mux.sv]
// Routes one of the stored values 0 to 7 to each of eight inputs.
// Assumes selector and value vectors come from registers on the same clock.
`timescale 1ns/1ps
module tcb_level_mux
   import tcb_pkg::*;
(
   input wire logic [79:0] levels,
   input wire logic [23:0] selects,
   output logic [79:0] routed
);
   // [R9] per-input value pick
   always_comb begin
      routed = '0;
      for (int n = 0; n < 8; n++) begin
         routed[n*10 +: 10] = levels[selects[n*3 +: 3]*10 +: 10];
      end
   end
endmodule

// [tcb_bank.sv]
// APB register bank holding ten 10-bit level values and an 8-input select map.
// Assumes a standard APB master on clk; every output is registered.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "tcb_consts.svh"
module tcb_bank
   import tcb_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output logic [79:0] level_values,
   output logic [79:0] input_levels,
   output logic [9:0] level_value_8,
   output logic [9:0] level_value_9
);
   logic [19:0] val_q [0:4];
   logic [19:0] val_d [0:4];
   logic [23:0] sel_q, sel_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   // Values 8 and 9 ride in the top twenty bits of the flattened copy
   logic [99:0] lv_q, lv_d;
   logic [79:0] il_q, il_d;
   logic [79:0] routed;
   tcb_state_t st_q, st_d;

   // Index from byte address; misaligned or high addresses decode as unmapped
   function automatic logic [3:0] reg_slot(input logic [31:0] a);
      logic [3:0] s;
      s = 4'hf;
      if (a[1:0] == 2'b00 && a[31:10] == '0) begin
         case (a[9:2])
            `TCB_IDX_VAL01: s = 4'h0;
            `TCB_IDX_VAL23: s = 4'h1;
            `TCB_IDX_VAL45: s = 4'h2;
            `TCB_IDX_VAL67: s = 4'h3;
            `TCB_IDX_VAL89: s = 4'h4;
            `TCB_IDX_SEL: s = 4'h5;
            default: s = 4'hf;
         endcase
      end
      return s;
   endfunction

   // Byte-lane merge with a writable-bit mask
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st, input logic [31:0] msk);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
      end
      return r & msk;
   endfunction

   // Only values 0 to 7 are selectable, so the router sees the low eight fields
   tcb_level_mux i_tcb_level_mux (
      .levels(lv_q[79:0]),
      .selects(sel_q),
      .routed(routed)
   );

   // Bus state and register next values; one wait state gives a two-cycle access
   always_comb begin
      logic [3:0] slot;
      slot = reg_slot(paddr);
      st_d = st_q;
      sel_d = sel_q;
      for (int i = 0; i < 5; i++) val_d[i] = val_q[i];
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      case (st_q)
         TCB_IDLE: begin
            if (psel && penable) begin
               st_d = TCB_ACCESS;
               pready_d = 1'b1;
               pslverr_d = (slot == 4'hf);
               prdata_d = 32'h00000000;
               if (pwrite) begin
                  // [R1] [R2] [R3] [R4] [R5] value field writes
                  // [R7] [R12] reserved bits masked off
                  if (slot < 4'h5)
                     val_d[slot[2:0]] = 20'(merge({12'h000, val_q[slot[2:0]]}, pwdata, pstrb,
                                                  `TCB_VAL_MASK));
                  // [R8] selector write
                  if (slot == 4'h5)
                     sel_d = 24'(merge({8'h00, sel_q}, pwdata, pstrb, `TCB_SEL_MASK));
               end else begin
                  // [R7] reserved bits read zero
                  if (slot < 4'h5) prdata_d = {12'h000, val_q[slot[2:0]]};
                  if (slot == 4'h5) prdata_d = {8'h00, sel_q};
               end
            end
         end
         TCB_ACCESS: st_d = TCB_IDLE;
         default: st_d = TCB_IDLE;
      endcase
   end

   // Flatten values; [R6] LSB of each field sits at its lowest bit
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         lv_d[i*20 +: 10] = val_q[i][`TCB_LO_LSB +: `TCB_VAL_W];
         lv_d[i*20+10 +: 10] = val_q[i][`TCB_HI_LSB +: `TCB_VAL_W];
      end
      il_d = routed;
   end

   // [R10] reset values; [R4] [R5] undefined reset chosen as zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= TCB_IDLE;
         for (int i = 0; i < 5; i++) val_q[i] <= {`TCB_VAL_RST, `TCB_VAL_RST};
         sel_q <= `TCB_SEL_RST;
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         lv_q <= '0;
         il_q <= '0;
      end else begin
         st_q <= st_d;
         for (int i = 0; i < 5; i++) val_q[i] <= val_d[i];
         sel_q <= sel_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         lv_q <= lv_d;
         il_q <= il_d;
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;
   assign level_values = lv_q[79:0];
   assign input_levels = il_q;
   // [R11] values 8 and 9 for the highest channels
   assign level_value_8 = lv_q[80 +: 10];
   assign level_value_9 = lv_q[90 +: 10];

   // Assertions
   a_ready_pulse: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
      pready |=> !pready) else $error("pready held two cycles");
   a_ready_timing: assert property (@(posedge clk) disable iff (!arst_n) // [R1]
      (psel && penable && !pready) |=> pready) else $error("pready late");
   a_resv_read: assert property (@(posedge clk) disable iff (!arst_n) // [R7]
      (pready && !pwrite && reg_slot(paddr) < 4'h5) |-> prdata[31:20] == 12'h000)
      else $error("reserved bits nonzero");
   a_sel_read: assert property (@(posedge clk) disable iff (!arst_n) // [R8]
      (pready && !pwrite && reg_slot(paddr) == 4'h5) |-> prdata == {8'h00, sel_q})
      else $error("select readback wrong");
   a_sel_write: assert property (@(posedge clk) disable iff (!arst_n) // [R8]
      (psel && penable && !pready && pwrite && reg_slot(paddr) == 4'h5 && pstrb == 4'hf)
      |=> sel_q == $past(pwdata[23:0])) else $error("selector not stored");
   // Routing is registered, so the output follows the previous cycle's map and values
   a_sel_route: assert property (@(posedge clk) disable iff (!arst_n) // [R9]
      $stable(sel_q) && $stable(lv_q) |=> input_levels[0 +: 10] == $past(lv_q[sel_q[2:0]*10 +: 10]))
      else $error("input 0 routing wrong");
   a_val0_write: assert property (@(posedge clk) disable iff (!arst_n) // [R1]
      (psel && penable && !pready && pwrite && reg_slot(paddr) == 4'h0 && pstrb == 4'hf)
      |=> ##1 level_values[9:0] == $past(pwdata[9:0], 2)) else $error("value 0 not stored");
   a_val8_out: assert property (@(posedge clk) disable iff (!arst_n) // [R11]
      $stable(val_q[4]) |=> level_value_8 == $past(val_q[4][9:0])) else $error("value 8 wrong");
   a_val9_out: assert property (@(posedge clk) disable iff (!arst_n) // [R11]
      $stable(val_q[4]) |=> level_value_9 == $past(val_q[4][19:10])) else $error("value 9 wrong");
   a_unmapped_err: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
      (psel && penable && !pready && reg_slot(paddr) == 4'hf) |=> pslverr)
      else $error("unmapped not flagged");
endmodule

// [tb.sv]
// Self-checking bench for the level value and input select register bank.
// Assumes the bank answers APB with one wait state and registers all outputs.
`timescale 1ns/1ps
`include "tcb_consts.svh"
module tb import tcb_pkg::*;;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [79:0] level_values, input_levels;
   logic [99:0] all_lv;
   tcb_level_t level_value_8, level_value_9;
   tcb_level_t vals [10];
   int fail_count = 0;
   int total_checks = 0;
   tcb_bank i_tcb_bank (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .level_values(level_values), .input_levels(input_levels), .level_value_8(level_value_8),
      .level_value_9(level_value_9));
   // All ten stored values side by side, value k at bits 10k+9:10k
   assign all_lv = {level_value_9, level_value_8, level_values};
   // Free running 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic results();
      if (fail_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; an idle edge follows so the next setup never lands in the same step
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {22'h0, idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail_count++;
         $display("[ERR] %0t no pready", $time);
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      // All six registers start at zero
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, `TCB_IDX_VAL01 + 8'(i), 32'h0);
         check(rd, 32'h0);
      end
      // All-ones writes: reserved bits must stay zero
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, `TCB_IDX_VAL01 + 8'(i), 32'hffffffff);
         apb(1'b0, `TCB_IDX_VAL01 + 8'(i), 32'h0);
         check(rd, (i == 5) ? `TCB_SEL_MASK : `TCB_VAL_MASK);
      end
      // Distinct uneven values expose swapped or shifted fields
      for (int k = 0; k < 10; k++) vals[k] = 10'(k * 113 + 1);
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, `TCB_IDX_VAL01 + 8'(i), {12'hfff, vals[2*i+1], vals[2*i]});
         apb(1'b0, `TCB_IDX_VAL01 + 8'(i), 32'h0);
         check(rd, {12'h0, vals[2*i+1], vals[2*i]});
         check({22'h0, all_lv[20*i+:10]}, {22'h0, vals[2*i]});
         check({22'h0, all_lv[20*i+10+:10]}, {22'h0, vals[2*i+1]});
      end
      check({12'h0, level_value_9, level_value_8}, {12'h0, vals[9], vals[8]});
      // Input n selects value 7-n, so every selector code is used
      apb(1'b1, `TCB_IDX_SEL, 32'hff053977);
      apb(1'b0, `TCB_IDX_SEL, 32'h0);
      check(rd, 32'h00053977);
      repeat (2) @(posedge clk);
      for (int n = 0; n < 8; n++) begin
         check({22'h0, input_levels[10*n+:10]}, {22'h0, vals[7-n]});
      end
      // A second reset in mid-run clears the selector map again
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, `TCB_IDX_SEL, 32'h0);
      check(rd, 32'h0);
      check({22'h0, input_levels[70+:10]}, 32'h0);
      // Unmapped places are refused and read zero
      apb(1'b1, 8'h30, 32'h12345678);
      check({31'h0, err}, 32'h1);
      apb(1'b0, 8'h28, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      results();
   end
endmodule
